// ---- lsw_pkg.sv ----
// Package with constants and types for the loop status word block.
// Contract
// - Set bit 15 when the parameter save to nonvolatile memory finishes.
// - Host save request bit starts the RAM to EEPROM write.
// - Save request clears the save-completed flag so each save is signalled afresh.
// - Save-completed flag stays clear after power-up until a save completes.
// - Bit 14 set when sensor absent, broken, or input out of range.
// - Bit 12 set on cold-junction compensator fault or host watchdog error.
// - Bit 11 set while waiting for first I/O refresh after power-up or restart.
// - Bit 10 set when autotuning has produced new PID constants.
// - Bit 10 clear once the host's PID constants have been transferred.
// - Bit 9 set whenever a received host setting is invalid.
// - Bit 8 clear while controlling, set while control is stopped.
// - Bit 4 follows the loop's control output.
// - Bit 3 set exactly while autotuning is in progress.
// - Bits 1 and 0 set while temperature lies inside alarm ranges one and two.
// - Unused bits 13, 7 to 5 and 2 read as zero.
`default_nettype none
package lsw_pkg;
  localparam logic [7:0] LOOP4_STATUS_WORD_OFS = 8'h13;
  localparam logic [7:0] SAVE_REQ_WORD_OFS     = 8'h0C;
  localparam int         SAVE_REQ_BIT          = 14;
  localparam int         BIT_SAVE_DONE         = 15;
  localparam int         BIT_SENSOR_ERR        = 14;
  localparam int         BIT_FATAL_ERR         = 12;
  localparam int         BIT_STANDBY           = 11;
  localparam int         BIT_PID_NEW           = 10;
  localparam int         BIT_SET_ERR           = 9;
  localparam int         BIT_STOP              = 8;
  localparam int         BIT_CTRL_OUT          = 4;
  localparam int         BIT_AUTOTUNE          = 3;
  localparam int         BIT_ALARM_ONE         = 1;
  localparam int         BIT_ALARM_TWO         = 0;
  localparam logic [15:0] STATUS_RST           = 16'h0800;
  localparam logic [15:0] STATUS_USED_MASK     = 16'hDF1B;

  typedef enum logic [1:0] {
    LSW_IDLE,
    LSW_SAVING
  } lsw_save_st_t;

  typedef struct packed {
    logic sensor_absent;
    logic sensor_broken;
    logic input_out_of_range;
    logic cjc_fault;
    logic host_wdt_err;
    logic setting_err;
    logic ctrl_stopped;
    logic ctrl_out_on;
    logic autotune_busy;
    logic alarm_one_in;
    logic alarm_two_in;
  } lsw_cond_t;

  typedef struct packed {
    logic         save_req_d;
    lsw_save_st_t save_st;
    logic         save_done;
    logic         pid_new;
    logic         standby;
    logic [15:0]  status;
  } lsw_state_t;
endpackage
`default_nettype wire

// ---- lsw_status.sv ----
// Loop status word logic for loop 4, presented to the host on each I/O refresh.
`default_nettype none
module lsw_status (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              unit_restart,
  input  wire logic              io_refresh,
  input  wire logic              save_req,
  output logic                   save_start,
  input  wire logic              save_write_done,
  input  wire logic              pid_calc_update,
  input  wire logic              pid_transfer_done,
  input  wire lsw_pkg::lsw_cond_t cond,
  output logic [15:0]            loop4_status_word
);

  lsw_pkg::lsw_state_t st_r;
  lsw_pkg::lsw_state_t st_nxt;
  logic                save_req_rise;

  assign save_req_rise = save_req & ~st_r.save_req_d;
  assign save_start    = clk_en & save_req_rise & (st_r.save_st == lsw_pkg::LSW_IDLE);

  function automatic logic [15:0] pack_word(input lsw_pkg::lsw_state_t s, input lsw_pkg::lsw_cond_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[lsw_pkg::BIT_SAVE_DONE]  = s.save_done;
    w[lsw_pkg::BIT_SENSOR_ERR] = c.sensor_absent | c.sensor_broken | c.input_out_of_range;
    w[lsw_pkg::BIT_FATAL_ERR]  = c.cjc_fault | c.host_wdt_err;
    w[lsw_pkg::BIT_STANDBY]    = s.standby;
    w[lsw_pkg::BIT_PID_NEW]    = s.pid_new;
    w[lsw_pkg::BIT_SET_ERR]    = c.setting_err;
    w[lsw_pkg::BIT_STOP]       = c.ctrl_stopped;
    w[lsw_pkg::BIT_CTRL_OUT]   = c.ctrl_out_on;
    w[lsw_pkg::BIT_AUTOTUNE]   = c.autotune_busy;
    w[lsw_pkg::BIT_ALARM_ONE]  = c.alarm_one_in;
    w[lsw_pkg::BIT_ALARM_TWO]  = c.alarm_two_in;
    return w & lsw_pkg::STATUS_USED_MASK;
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.save_req_d = save_req;
    case (st_r.save_st)
      lsw_pkg::LSW_IDLE:
      begin
        if (save_req_rise)
        begin
          st_nxt.save_st = lsw_pkg::LSW_SAVING;
        end
      end
      lsw_pkg::LSW_SAVING:
      begin
        if (save_write_done)
        begin
          st_nxt.save_st   = lsw_pkg::LSW_IDLE;
          st_nxt.save_done = 1'b1;
        end
      end
      default:
      begin
        st_nxt.save_st = lsw_pkg::LSW_IDLE;
      end
    endcase
    // A new request clears the flag, unless it arrives in the cycle a running save completes; then the completion sets it.
    if (save_req_rise && !(st_r.save_st == lsw_pkg::LSW_SAVING && save_write_done))
    begin
      st_nxt.save_done = 1'b0;
    end
    // New constants win over a transfer in the same cycle, so the update is not lost.
    if (pid_calc_update)
    begin
      st_nxt.pid_new = 1'b1;
    end
    else if (pid_transfer_done)
    begin
      st_nxt.pid_new = 1'b0;
    end
    if (unit_restart)
    begin
      st_nxt.standby = 1'b1;
    end
    else if (io_refresh)
    begin
      st_nxt.standby = 1'b0;
    end
    // The word is captured in one cycle at each refresh so the host sees a coherent snapshot.
    if (io_refresh)
    begin
      st_nxt.status = pack_word(st_r, cond);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r.save_req_d <= 1'b0;
      st_r.save_st   <= lsw_pkg::LSW_IDLE;
      st_r.save_done <= 1'b0;
      st_r.pid_new   <= 1'b0;
      st_r.standby   <= 1'b1;
      st_r.status    <= lsw_pkg::STATUS_RST;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  assign loop4_status_word = st_r.status;

  a_save_done_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && save_req_rise && st_r.save_st == lsw_pkg::LSW_IDLE |=> !st_r.save_done)
    else $error("save done flag not cleared by request");
  a_save_done_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && st_r.save_st == lsw_pkg::LSW_SAVING && save_write_done |=> st_r.save_done)
    else $error("save done flag not set on completion");
  a_save_done_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(st_r.save_done) && st_r.save_done |-> $past(save_write_done))
    else $error("save done flag rose without a completion");
  a_save_start_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
    save_start |=> st_r.save_st == lsw_pkg::LSW_SAVING)
    else $error("save start did not enter saving state");
  a_unused_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (loop4_status_word & ~lsw_pkg::STATUS_USED_MASK) == 16'h0000)
    else $error("unused status bits not zero");
  a_snap_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh && !cond.ctrl_stopped |=> !loop4_status_word[lsw_pkg::BIT_STOP])
    else $error("stop bit snapshot wrong");
  a_snap_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !io_refresh |=> $stable(loop4_status_word))
    else $error("status word changed between refreshes");
  a_sensor_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh && cond.sensor_broken |=> loop4_status_word[lsw_pkg::BIT_SENSOR_ERR])
    else $error("sensor error bit not set");
  a_fatal_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh && cond.host_wdt_err |=> loop4_status_word[lsw_pkg::BIT_FATAL_ERR])
    else $error("fatal error bit not set");
  a_pid_new_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && pid_calc_update |=> st_r.pid_new)
    else $error("pid new flag not set");
  a_pid_xfer_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && pid_transfer_done && !pid_calc_update |=> !st_r.pid_new)
    else $error("pid new flag not cleared on transfer");
  a_standby_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh && !unit_restart |=> !st_r.standby)
    else $error("standby not cleared by refresh");

  // A frozen clock enable must leave the presented word and the save launch untouched.
  a_freeze_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> $stable(loop4_status_word))
    else $error("status word changed while clock enable low");
  a_freeze_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |-> !save_start)
    else $error("save start pulsed while clock enable low");
  a_busy_no_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r.save_st == lsw_pkg::LSW_SAVING |-> !save_start)
    else $error("save start pulsed while a save runs");
  a_restart_sby: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && unit_restart |=> st_r.standby)
    else $error("standby not set by unit restart");

  // Each flag and single-source bit must match its value sampled at the refresh edge; each error source must set its bit.
  a_save_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh |=> loop4_status_word[lsw_pkg::BIT_SAVE_DONE] == $past(st_r.save_done))
    else $error("save done bit does not match flag");
  a_sby_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh |=> loop4_status_word[lsw_pkg::BIT_STANDBY] == $past(st_r.standby))
    else $error("standby bit does not match flag");
  a_pid_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh |=> loop4_status_word[lsw_pkg::BIT_PID_NEW] == $past(st_r.pid_new))
    else $error("pid bit does not match flag");
  a_sensor_absent: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh && cond.sensor_absent |=> loop4_status_word[lsw_pkg::BIT_SENSOR_ERR])
    else $error("sensor error bit not set for absent sensor");
  a_sensor_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh && cond.input_out_of_range |=> loop4_status_word[lsw_pkg::BIT_SENSOR_ERR])
    else $error("sensor error bit not set for out of range input");
  a_cjc_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh && cond.cjc_fault |=> loop4_status_word[lsw_pkg::BIT_FATAL_ERR])
    else $error("fatal error bit not set for compensator fault");
  a_set_err_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh |=> loop4_status_word[lsw_pkg::BIT_SET_ERR] == $past(cond.setting_err))
    else $error("setting error bit wrong");
  a_stop_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh |=> loop4_status_word[lsw_pkg::BIT_STOP] == $past(cond.ctrl_stopped))
    else $error("stop bit wrong");
  a_ctrl_out_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh |=> loop4_status_word[lsw_pkg::BIT_CTRL_OUT] == $past(cond.ctrl_out_on))
    else $error("control output bit wrong");
  a_autotune_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh |=> loop4_status_word[lsw_pkg::BIT_AUTOTUNE] == $past(cond.autotune_busy))
    else $error("autotune bit wrong");
  a_alarm_one_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh |=> loop4_status_word[lsw_pkg::BIT_ALARM_ONE] == $past(cond.alarm_one_in))
    else $error("alarm one bit wrong");
  a_alarm_two_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && io_refresh |=> loop4_status_word[lsw_pkg::BIT_ALARM_TWO] == $past(cond.alarm_two_in))
    else $error("alarm two bit wrong");

endmodule
`default_nettype wire

// ---- lsw_host.sv ----
// Model of the nonvolatile memory writer that answers the save start pulse.
`default_nettype none
module lsw_host (
  input  wire logic       ref_clk,
  input  wire logic       save_start,
  input  wire logic [3:0] wr_delay,
  output logic            save_write_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  logic       busy_r;
  initial
  begin
    busy_r = 1'b0;
    cnt_r = 4'h0;
    save_write_done = 1'b0;
  end
  // The write takes wr_delay plus one cycles, so the bench can pick a prompt or a slow memory.
  always @(posedge ref_clk)
  begin
    save_write_done <= 1'b0;
    if (save_start)
    begin
      busy_r <= 1'b1;
      cnt_r <= wr_delay;
    end
    else if (busy_r && cnt_r == 4'h0)
    begin
      busy_r <= 1'b0;
      save_write_done <= 1'b1;
    end
    else if (busy_r)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule
`default_nettype wire

// ---- test_lsw_status.sv ----
// Self-checking testbench for the loop status word block.
`default_nettype none
module test_lsw_status;
  timeunit 1ns;
  timeprecision 1ns;
  logic               ref_clk;
  logic               rst_n;
  logic               clk_en;
  logic               unit_restart;
  logic               io_refresh;
  logic               save_req;
  logic               save_start;
  logic               save_write_done;
  logic               pid_calc_update;
  logic               pid_transfer_done;
  lsw_pkg::lsw_cond_t cond;
  logic [15:0]        loop4_status_word;
  logic [3:0]         wr_delay;
  int                 miscompares;
  int                 check_count;
  lsw_status dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .unit_restart(unit_restart),
    .io_refresh(io_refresh), .save_req(save_req), .save_start(save_start), .save_write_done(save_write_done),
    .pid_calc_update(pid_calc_update), .pid_transfer_done(pid_transfer_done), .cond(cond),
    .loop4_status_word(loop4_status_word));
  lsw_host host (.ref_clk(ref_clk), .save_start(save_start), .wr_delay(wr_delay),
    .save_write_done(save_write_done));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic refresh_chk(input string name, input logic [15:0] exp);
    io_refresh = 1'b1;
    step(1);
    io_refresh = 1'b0;
    step(1);
    check(name, loop4_status_word, exp);
  endtask
  task automatic t_standby();
    refresh_chk("standby", 16'h0800);
    refresh_chk("idle", 16'h0000);
  endtask
  task automatic t_freeze();
    clk_en = 1'b0;
    cond = 11'h001;
    io_refresh = 1'b1;
    save_req = 1'b1;
    #1;
    check("frozen_start", {15'h0000, save_start}, 16'h0000);
    step(1);
    io_refresh = 1'b0;
    save_req = 1'b0;
    step(1);
    check("frozen_word", loop4_status_word, 16'h0000);
    clk_en = 1'b1;
    cond = '0;
    step(1);
  endtask
  task automatic t_cond();
    logic [15:0] map [11] = '{16'h0001, 16'h0002, 16'h0008, 16'h0010, 16'h0100, 16'h0200,
      16'h1000, 16'h1000, 16'h4000, 16'h4000, 16'h4000};
    for (int i = 0; i < 11; i++)
    begin
      cond = 11'h001 << i;
      refresh_chk("cond", map[i]);
    end
    cond = 11'h7FF;
    refresh_chk("all", 16'h531B);
    cond = '0;
  endtask
  task automatic t_pid();
    pid_calc_update = 1'b1;
    step(1);
    pid_calc_update = 1'b0;
    refresh_chk("pid", 16'h0400);
    pid_transfer_done = 1'b1;
    step(1);
    pid_transfer_done = 1'b0;
    refresh_chk("xfer", 16'h0000);
  endtask
  task automatic t_save();
    save_req = 1'b1;
    #1;
    check("start", {15'h0000, save_start}, 16'h0001);
    step(6);
    save_req = 1'b0;
    refresh_chk("done", 16'h8000);
    wr_delay = 4'h9;
    save_req = 1'b1;
    step(1);
    refresh_chk("clear", 16'h0000);
    step(12);
    refresh_chk("redone", 16'h8000);
    save_req = 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    unit_restart = 1'b0;
    io_refresh = 1'b0;
    save_req = 1'b0;
    pid_calc_update = 1'b0;
    pid_transfer_done = 1'b0;
    cond = '0;
    wr_delay = 4'h2;
    miscompares = 0;
    check_count = 0;
    step(10);
    rst_n = 1'b1;
    step(1);
    t_standby();
    t_cond();
    t_pid();
    t_freeze();
    unit_restart = 1'b1;
    step(1);
    unit_restart = 1'b0;
    t_standby();
    t_save();
    end_sim();
  end
  initial
  begin
    #300000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
